// ===== opm_consts.svh
// Constants for the operation-mode controller: command word layout, register
// indices, reset values and mode status codes.
// Assumes it is included by its bare name from the package and the modules.
`ifndef OPM_CONSTS_SVH
`define OPM_CONSTS_SVH

// Command word layout, 16 bits shifted in MSB first.
`define OPM_WORD_W 16
`define OPM_CMD_WR_BIT 15
`define OPM_CMD_ADDR_HI 14
`define OPM_CMD_ADDR_LO 12
`define OPM_CMD_DATA_HI 7
`define OPM_CMD_DATA_LO 0

// Register indices carried in the address field.
`define OPM_ADDR_CHAN_ON 3'h0
`define OPM_ADDR_HW_CTRL 3'h1
`define OPM_ADDR_ROUTE_A 3'h2
`define OPM_ADDR_ROUTE_B 3'h3
`define OPM_ADDR_OL_TEST 3'h4
`define OPM_ADDR_MONITOR 3'h5
`define OPM_ADDR_FAULT 3'h6

// Field positions in the hardware control register.
`define OPM_HW_KEEP_BIT 0
`define OPM_HW_SRST_BIT 1

// Field positions in the response word.
`define OPM_RSP_MODE_HI 15
`define OPM_RSP_MODE_LO 14
`define OPM_RSP_TER_BIT 13
`define OPM_RSP_UV_BIT 12
`define OPM_RSP_LOP_BIT 11
`define OPM_RSP_FLT_HI 7
`define OPM_RSP_FLT_LO 4
`define OPM_RSP_DAT_HI 3
`define OPM_RSP_DAT_LO 0

// Register reset values and the Limp Home channel mask.
`define OPM_RST_CHAN_ON 4'h0
`define OPM_RST_KEEP 1'b0
`define OPM_RST_ROUTE_A 4'h4
`define OPM_RST_ROUTE_B 4'h8
`define OPM_RST_OL_TEST 4'h0
`define OPM_LIMP_CH_MASK 4'hC

// Mode status codes.
`define OPM_MCODE_IDLE 2'h0
`define OPM_MCODE_LIMP 2'h1
`define OPM_MCODE_ACTIVE 2'h2
`define OPM_MCODE_SLEEP 2'h3

`endif

// ===== opm_pkg.sv
// Types shared by the operation-mode controller and its serial link front end.
// Assumes opm_consts.svh is on the include path.
`include "opm_consts.svh"

package opm_pkg;

  // Operation modes of the device.
  typedef enum logic [1:0] {
    OPM_SLEEP,
    OPM_IDLE,
    OPM_ACTIVE,
    OPM_LIMP
  } opm_mode_t;

  // Supply monitor status levels from the analog comparators.
  typedef struct packed {
    logic vs_op_ok;
    logic vs_uv;
    logic vdd_uv;
    logic vdd_lop;
    logic vdd_above_lop;
  } opm_supply_t;

  // Serial words crossing between link and system domains.
  typedef logic [`OPM_WORD_W-1:0] opm_word_t;

endpackage

// ===== opm_link.sv
// Serial link front end: shifts command words in on the link clock and the
// response word out, and flags each complete word with a toggle.
// Assumes the link clock runs only while the frame select is low.
`timescale 1ns/1ps
`include "opm_consts.svh"

module opm_link (
  input wire logic link_clk,
  input wire logic resetn,
  input wire logic frame_sel_n,
  input wire logic mosi,
  input wire opm_pkg::opm_word_t resp_word,
  output logic miso,
  output logic miso_oe_n,
  output logic word_tgl,
  output opm_pkg::opm_word_t rx_word
);
  import opm_pkg::*;

  logic frame_rst_n;
  logic [3:0] bit_cnt_q;
  opm_word_t shift_q;
  opm_word_t tx_q;

  // A deselected frame clears the bit position without needing a clock edge.
  assign frame_rst_n = resetn & ~frame_sel_n;

  // Bit counter and input shifter live only for the duration of a frame.
  always_ff @(posedge link_clk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      bit_cnt_q <= 4'h0;
      shift_q <= 16'h0000;
    end else begin
      bit_cnt_q <= bit_cnt_q + 4'h1;
      shift_q <= {shift_q[14:0], mosi};
    end
  end

  // Completed words and their toggle must outlive the frame.
  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      rx_word <= 16'h0000;
      word_tgl <= 1'b0;
    end else if (!frame_sel_n && bit_cnt_q == 4'hF) begin
      rx_word <= {shift_q[14:0], mosi};
      word_tgl <= ~word_tgl;
    end
  end

  // The response is quiet between frames, so it is loaded at the first bit.
  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      tx_q <= 16'h0000;
    end else if (bit_cnt_q == 4'h0) begin
      tx_q <= {resp_word[14:0], 1'b0};
    end else begin
      tx_q <= {tx_q[14:0], 1'b0};
    end
  end

  // Output driven only while selected.
  assign miso = frame_sel_n ? 1'b0 : ((bit_cnt_q == 4'h0) ? resp_word[15] : tx_q[15]);
  assign miso_oe_n = frame_sel_n;

endmodule

// ===== opm_ctrl.sv
// Operation-mode and register-reset controller of a four-channel low-side switch.
// Assumes supply status and pins are asynchronous levels and the serial link
// runs on its own clock; frames are spaced by at least four system clocks.
`timescale 1ns/1ps
`include "opm_consts.svh"

module opm_ctrl #(
  parameter int NUM_CH = 4,
  parameter int NUM_IN = 2
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic link_clk,
  input wire logic frame_sel_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe_n,
  input wire logic idle_pin,
  input wire logic [NUM_IN-1:0] direct_ctrl_pin,
  input wire opm_pkg::opm_supply_t supply,
  input wire logic [NUM_CH-1:0] fault_event,
  input wire logic [NUM_CH-1:0] output_monitor_bit,
  output logic [NUM_CH-1:0] chan_drive,
  output logic diag_enable,
  output logic serial_ready,
  output logic [1:0] mode_code,
  output logic [NUM_CH-1:0] open_load_test_current_bit
);
  import opm_pkg::*;

  // Pin and supply synchronisers.
  logic [1:0] idle_s_q;
  logic [NUM_IN-1:0] din_s1_q;
  logic [NUM_IN-1:0] din_s2_q;
  opm_supply_t sup_s1_q;
  opm_supply_t sup_s2_q;
  logic [1:0] sel_s_q;
  logic sel_d_q;
  logic [2:0] tgl_s_q;

  opm_mode_t mode_q;
  opm_mode_t mode_d;
  logic [NUM_CH-1:0] channel_on_bit_q;
  logic keep_active_bit_q;
  logic [NUM_CH-1:0] input_route_mask_a_q;
  logic [NUM_CH-1:0] input_route_mask_b_q;
  logic [NUM_CH-1:0] channel_fault_flag_q;
  logic load_supply_low_flag_q;
  logic logic_supply_low_power_flag_q;
  logic transmission_error_flag_q;
  logic limp_first_q;
  logic word_seen_q;
  opm_word_t resp_q;

  opm_word_t rx_word;
  logic word_tgl;
  logic idle_hi;
  logic any_in;
  logic any_chan;
  logic power_on;
  logic cmd_vld;
  logic cmd_wr;
  logic [2:0] cmd_addr;
  logic [NUM_CH-1:0] cmd_data;
  logic wr_ok;
  logic soft_reset_bit;
  logic regs_clr;
  logic frame_end;
  logic bad_frame;
  logic [NUM_CH-1:0] routed;

  // Selects one input's route mask as a channel vector.
  function automatic logic [NUM_CH-1:0] route_of(input logic pin,
                                                 input logic [NUM_CH-1:0] mask);
    route_of = pin ? mask : '0;
  endfunction

  // Serial front end on the link clock.
  opm_link u_link (
    .link_clk(link_clk),
    .resetn(resetn),
    .frame_sel_n(frame_sel_n),
    .mosi(mosi),
    .resp_word(resp_q),
    .miso(miso),
    .miso_oe_n(miso_oe_n),
    .word_tgl(word_tgl),
    .rx_word(rx_word)
  );

  // Two-stage synchronisers for every asynchronous level.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      idle_s_q <= 2'h0;
      din_s1_q <= '0;
      din_s2_q <= '0;
      sup_s1_q <= '0;
      sup_s2_q <= '0;
      sel_s_q <= 2'h3;
      sel_d_q <= 1'b1;
      tgl_s_q <= 3'h0;
    end else begin
      idle_s_q <= {idle_s_q[0], idle_pin};
      din_s1_q <= direct_ctrl_pin;
      din_s2_q <= din_s1_q;
      sup_s1_q <= supply;
      sup_s2_q <= sup_s1_q;
      sel_s_q <= {sel_s_q[0], frame_sel_n};
      sel_d_q <= sel_s_q[1];
      tgl_s_q <= {tgl_s_q[1:0], word_tgl};
    end
  end

  assign idle_hi = idle_s_q[1];
  assign any_in = |din_s2_q;
  assign any_chan = |channel_on_bit_q;
  assign power_on = sup_s2_q.vs_op_ok | sup_s2_q.vdd_above_lop;

  // Command decode; the received word is stable until the next frame ends.
  assign cmd_vld = tgl_s_q[2] ^ tgl_s_q[1];
  assign cmd_wr = rx_word[`OPM_CMD_WR_BIT];
  assign cmd_addr = rx_word[`OPM_CMD_ADDR_HI:`OPM_CMD_ADDR_LO];
  assign cmd_data = rx_word[NUM_CH-1:`OPM_CMD_DATA_LO];
  assign frame_end = sel_s_q[1] & ~sel_d_q;
  assign bad_frame = frame_end & ~word_seen_q & ~cmd_vld;

  // Writes land only where registers are operational; Limp Home drops them.
  assign wr_ok = cmd_vld & cmd_wr & (mode_q == OPM_IDLE || mode_q == OPM_ACTIVE)
                 & ~regs_clr;
  assign soft_reset_bit = wr_ok & (cmd_addr == `OPM_ADDR_HW_CTRL)
                          & cmd_data[`OPM_HW_SRST_BIT];

  // Register reset sources: sleep, logic undervoltage, idle pin low, soft reset.
  assign regs_clr = (mode_q == OPM_SLEEP) | sup_s2_q.vdd_uv | ~idle_hi;

  // Next operation mode.
  always_comb begin
    mode_d = mode_q;
    if (!power_on || (!idle_hi && !any_in)) begin
      mode_d = OPM_SLEEP;
    end else begin
      unique case (mode_q)
        OPM_SLEEP: begin
          if (!idle_hi) begin
            mode_d = OPM_LIMP;
          end else if (any_in) begin
            mode_d = OPM_ACTIVE;
          end else begin
            mode_d = OPM_IDLE;
          end
        end
        OPM_IDLE: begin
          if (!idle_hi) begin
            mode_d = OPM_LIMP;
          end else if (any_in || (any_chan && !sup_s2_q.vdd_uv)) begin
            mode_d = OPM_ACTIVE;
          end
        end
        OPM_ACTIVE: begin
          if (!idle_hi) begin
            mode_d = OPM_LIMP;
          end else if (sup_s2_q.vdd_uv && !any_in) begin
            mode_d = OPM_IDLE;
          end else if (!keep_active_bit_q && !any_in && !any_chan) begin
            mode_d = OPM_IDLE;
          end
        end
        OPM_LIMP: begin
          if (idle_hi) begin
            mode_d = any_in ? OPM_ACTIVE : OPM_IDLE;
          end
        end
      endcase
    end
  end

  // Operation mode register.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mode_q <= OPM_SLEEP;
    end else begin
      mode_q <= mode_d;
    end
  end

  // Control registers, returned to defaults by any register reset.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      channel_on_bit_q <= `OPM_RST_CHAN_ON;
      keep_active_bit_q <= `OPM_RST_KEEP;
      input_route_mask_a_q <= `OPM_RST_ROUTE_A;
      input_route_mask_b_q <= `OPM_RST_ROUTE_B;
      open_load_test_current_bit <= `OPM_RST_OL_TEST;
    end else if (regs_clr || soft_reset_bit) begin
      channel_on_bit_q <= `OPM_RST_CHAN_ON;
      keep_active_bit_q <= `OPM_RST_KEEP;
      input_route_mask_a_q <= `OPM_RST_ROUTE_A;
      input_route_mask_b_q <= `OPM_RST_ROUTE_B;
      open_load_test_current_bit <= `OPM_RST_OL_TEST;
    end else if (wr_ok) begin
      unique case (cmd_addr)
        `OPM_ADDR_CHAN_ON: channel_on_bit_q <= cmd_data;
        `OPM_ADDR_HW_CTRL: keep_active_bit_q <= cmd_data[`OPM_HW_KEEP_BIT];
        `OPM_ADDR_ROUTE_A: input_route_mask_a_q <= cmd_data;
        `OPM_ADDR_ROUTE_B: input_route_mask_b_q <= cmd_data;
        `OPM_ADDR_OL_TEST: open_load_test_current_bit <= cmd_data;
        default: begin
        end
      endcase
    end
  end

  // Fault flags: sticky, set wins, cleared by writing ones in Active.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      channel_fault_flag_q <= '0;
    end else if (mode_q == OPM_SLEEP || (sup_s2_q.vdd_uv && mode_q != OPM_IDLE)) begin
      channel_fault_flag_q <= fault_event;
    end else if (wr_ok && cmd_addr == `OPM_ADDR_FAULT && mode_q != OPM_IDLE) begin
      channel_fault_flag_q <= (channel_fault_flag_q & ~cmd_data) | fault_event;
    end else begin
      channel_fault_flag_q <= channel_fault_flag_q | fault_event;
    end
  end

  // Supply flags: set by the monitor, forced in Limp Home, cleared on readout.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      load_supply_low_flag_q <= 1'b0;
      logic_supply_low_power_flag_q <= 1'b0;
    end else if (mode_q == OPM_LIMP) begin
      load_supply_low_flag_q <= 1'b1;
      logic_supply_low_power_flag_q <= 1'b1;
    end else if (soft_reset_bit) begin
      load_supply_low_flag_q <= sup_s2_q.vs_uv;
      logic_supply_low_power_flag_q <= sup_s2_q.vdd_lop;
    end else if (cmd_vld) begin
      load_supply_low_flag_q <= sup_s2_q.vs_uv;
      logic_supply_low_power_flag_q <= sup_s2_q.vdd_lop;
    end else begin
      load_supply_low_flag_q <= load_supply_low_flag_q | sup_s2_q.vs_uv;
      logic_supply_low_power_flag_q <= logic_supply_low_power_flag_q | sup_s2_q.vdd_lop;
    end
  end

  // Frame tracking for the transmission error flag.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      word_seen_q <= 1'b0;
    end else if (frame_end) begin
      word_seen_q <= 1'b0;
    end else if (cmd_vld) begin
      word_seen_q <= 1'b1;
    end
  end

  // Transmission error: framing faults, and the first command in Limp Home.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      limp_first_q <= 1'b0;
      transmission_error_flag_q <= 1'b0;
    end else begin
      if (mode_q != OPM_LIMP && mode_d == OPM_LIMP) begin
        limp_first_q <= 1'b1;
      end else if (cmd_vld) begin
        limp_first_q <= 1'b0;
      end
      if (bad_frame || (cmd_vld && limp_first_q)) begin
        transmission_error_flag_q <= 1'b1;
      end else if (cmd_vld) begin
        transmission_error_flag_q <= 1'b0;
      end
    end
  end

  // Response word loaded after each command, read back in the next frame.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      resp_q <= 16'h0000;
    end else if (cmd_vld || bad_frame) begin
      resp_q <= 16'h0000;
      resp_q[`OPM_RSP_MODE_HI:`OPM_RSP_MODE_LO] <= mode_code;
      resp_q[`OPM_RSP_TER_BIT] <= transmission_error_flag_q | limp_first_q | bad_frame;
      resp_q[`OPM_RSP_UV_BIT] <= load_supply_low_flag_q;
      resp_q[`OPM_RSP_LOP_BIT] <= logic_supply_low_power_flag_q;
      resp_q[`OPM_RSP_FLT_HI:`OPM_RSP_FLT_LO] <= channel_fault_flag_q;
      unique case (cmd_addr)
        `OPM_ADDR_CHAN_ON: resp_q[`OPM_RSP_DAT_HI:`OPM_RSP_DAT_LO] <= channel_on_bit_q;
        `OPM_ADDR_HW_CTRL: resp_q[`OPM_RSP_DAT_LO] <= keep_active_bit_q;
        `OPM_ADDR_ROUTE_A: resp_q[`OPM_RSP_DAT_HI:`OPM_RSP_DAT_LO] <= input_route_mask_a_q;
        `OPM_ADDR_ROUTE_B: resp_q[`OPM_RSP_DAT_HI:`OPM_RSP_DAT_LO] <= input_route_mask_b_q;
        `OPM_ADDR_OL_TEST:
          resp_q[`OPM_RSP_DAT_HI:`OPM_RSP_DAT_LO] <= open_load_test_current_bit;
        `OPM_ADDR_MONITOR: resp_q[`OPM_RSP_DAT_HI:`OPM_RSP_DAT_LO] <= output_monitor_bit;
        default: resp_q[`OPM_RSP_DAT_HI:`OPM_RSP_DAT_LO] <= channel_fault_flag_q;
      endcase
    end
  end

  // Channel routing from the direct-control pins.
  assign routed = route_of(din_s2_q[0], input_route_mask_a_q)
                  | route_of(din_s2_q[1], input_route_mask_b_q);

  // Channel drive and status outputs, all registered.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      chan_drive <= '0;
      diag_enable <= 1'b0;
      serial_ready <= 1'b0;
      mode_code <= `OPM_MCODE_SLEEP;
    end else begin
      unique case (mode_q)
        OPM_SLEEP: begin
          chan_drive <= '0;
          mode_code <= `OPM_MCODE_SLEEP;
        end
        OPM_IDLE: begin
          chan_drive <= '0;
          mode_code <= `OPM_MCODE_IDLE;
        end
        OPM_ACTIVE: begin
          chan_drive <= channel_on_bit_q | routed;
          mode_code <= `OPM_MCODE_ACTIVE;
        end
        OPM_LIMP: begin
          chan_drive <= routed & `OPM_LIMP_CH_MASK;
          mode_code <= `OPM_MCODE_LIMP;
        end
      endcase
      diag_enable <= (mode_q == OPM_ACTIVE);
      serial_ready <= (mode_q != OPM_SLEEP) & ~sup_s2_q.vdd_uv;
    end
  end

endmodule

// ===== opm_ctrl_monitor.sv
// Checker for the mode controller, watching its top-level ports only.
// Assumes pin and supply changes reach the outputs within four system clocks.
`timescale 1ns/1ps
`include "opm_consts.svh"
module opm_ctrl_monitor #(
  parameter int NUM_CH = 4,
  parameter int NUM_IN = 2
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic idle_pin,
  input wire logic [NUM_IN-1:0] direct_ctrl_pin,
  input wire opm_pkg::opm_supply_t supply,
  input wire logic [NUM_CH-1:0] chan_drive,
  input wire logic diag_enable,
  input wire logic serial_ready,
  input wire logic [1:0] mode_code,
  input wire logic [NUM_CH-1:0] open_load_test_current_bit
);
  import opm_pkg::*;
  logic pwr;
  logic [NUM_CH-1:0] limp_ch;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  // Power-on level, and the channels that default routing lights in Limp Home.
  assign pwr = supply.vs_op_ok | supply.vdd_above_lop;
  assign limp_ch = NUM_CH'({direct_ctrl_pin[1], direct_ctrl_pin[0], 2'h0});

  AST_SLEEP_OFF: assert property (mode_code == `OPM_MCODE_SLEEP |->
    chan_drive == '0 && !serial_ready) else $error("output or serial live in sleep");
  AST_IDLE_OFF: assert property (mode_code == `OPM_MCODE_IDLE |->
    chan_drive == '0 && !diag_enable) else $error("output or diagnosis live in idle");
  AST_DIAG_ACTIVE: assert property (diag_enable |->
    mode_code == `OPM_MCODE_ACTIVE) else $error("diagnosis outside active");
  AST_LIMP_CH: assert property (mode_code == `OPM_MCODE_LIMP |->
    (chan_drive & ~`OPM_LIMP_CH_MASK) == '0) else $error("forbidden channel in limp");
  AST_LIMP_TEST: assert property (mode_code == `OPM_MCODE_LIMP |->
    open_load_test_current_bit == '0) else $error("test current on in limp");
  AST_ENTER_ACTIVE: assert property ((idle_pin && pwr && |direct_ctrl_pin)[*7] |->
    mode_code == `OPM_MCODE_ACTIVE && diag_enable) else $error("active not entered");
  AST_ENTER_LIMP: assert property ((!idle_pin && pwr && |direct_ctrl_pin
    && $stable(direct_ctrl_pin))[*7] |-> mode_code == `OPM_MCODE_LIMP && chan_drive == limp_ch)
    else $error("limp mode or its channels wrong");
  AST_NO_POWER: assert property ((!pwr)[*7] |->
    mode_code == `OPM_MCODE_SLEEP) else $error("awake without power-on");
  AST_PINS_LOW_SLEEP: assert property ((!idle_pin && direct_ctrl_pin == '0)[*7] |->
    mode_code == `OPM_MCODE_SLEEP) else $error("awake with idle and inputs low");
  AST_UV_IDLE: assert property ((idle_pin && pwr && supply.vdd_uv
    && direct_ctrl_pin == '0)[*7] |-> mode_code == `OPM_MCODE_IDLE) else $error("no idle on uv");

  // Main scenarios reached.
  cover property (mode_code == `OPM_MCODE_LIMP && chan_drive != '0);
  cover property ($rose(diag_enable));
  cover property (mode_code == `OPM_MCODE_SLEEP && idle_pin);
endmodule

// ===== opm_host_model.sv
// Host model: sends 16-bit words MSB first on the serial link, keeps each reply.
// Assumes the caller settles the mode before a frame; the model leaves 300 ns after.
`timescale 1ns/1ps
module opm_host_model (
  output logic link_clk,
  output logic frame_sel_n,
  output logic mosi,
  input wire logic miso
);
  import opm_pkg::*;
  opm_word_t rsp;
  event done_ev;
  initial begin
    link_clk = 1'h0;
    frame_sel_n = 1'h1;
    mosi = 1'h0;
    rsp = '0;
  end
  // One frame; the link clock runs only inside it, reply bits read before each edge.
  // Callers never frame during a mode change.
  task automatic xfer(input opm_word_t word);
    #37;
    frame_sel_n = 1'h0;
    for (int i = 15; i >= 0; i--) begin
      mosi = word[i];
      #62.5;
      rsp[i] = miso;
      link_clk = 1'h1;
      #62.5;
      link_clk = 1'h0;
    end
    frame_sel_n = 1'h1;
    mosi = ~mosi; // Released line has no pull, so it does not hold its value.
    -> done_ev;
    #300;
  endtask
endmodule

// ===== opm_ctrl_test.sv
// Self-checking bench for the mode controller with a host model on the link.
// Assumes the checker is bound below; expectations follow the mode rules.
`timescale 1ns/1ps
`include "opm_consts.svh"
module opm_ctrl_test;
  import opm_pkg::*;
  typedef struct packed {logic [20:0] v; logic [20:0] m;} opm_exp_t;
  localparam logic [20:0] K_SD = 21'h1F0000;
  localparam logic [20:0] K_MD = 21'h00C000;
  localparam logic [20:0] K_TE = 21'h002000;
  localparam logic [20:0] K_UL = 21'h001800;
  localparam logic [20:0] K_FL = 21'h0000F0;
  localparam logic [20:0] K_DA = 21'h00000F;
  localparam logic [1:0] MI = `OPM_MCODE_IDLE;
  localparam logic [1:0] MA = `OPM_MCODE_ACTIVE;
  localparam logic [1:0] ML = `OPM_MCODE_LIMP;
  logic clk_sys = 1'h0;
  logic resetn = 1'h0;
  logic idle_pin = 1'h0;
  logic [1:0] direct_ctrl_pin = 2'h0;
  opm_supply_t supply = 5'h11;
  logic [3:0] fault_event = 4'h0;
  logic [3:0] output_monitor_bit = 4'h0;
  logic link_clk, frame_sel_n, mosi, miso, miso_oe_n, diag_enable, serial_ready;
  logic [3:0] chan_drive, open_load_test_current_bit;
  logic [1:0] mode_code;
  logic [31:0] r;
  logic [1:0] p;
  logic [20:0] got;
  opm_exp_t e;
  opm_exp_t exp_q[$];
  int bad_count = 0;
  int checked = 0;
  int cycles = 0;
  int seed = 32'h5ce7;

  // System clock at 20 MHz.
  always #25 clk_sys = ~clk_sys;

  opm_ctrl dut (.clk_sys(clk_sys), .resetn(resetn), .link_clk(link_clk),
    .frame_sel_n(frame_sel_n), .mosi(mosi), .miso(miso), .miso_oe_n(miso_oe_n),
    .idle_pin(idle_pin), .direct_ctrl_pin(direct_ctrl_pin), .supply(supply),
    .fault_event(fault_event), .output_monitor_bit(output_monitor_bit),
    .chan_drive(chan_drive), .diag_enable(diag_enable), .serial_ready(serial_ready),
    .mode_code(mode_code), .open_load_test_current_bit(open_load_test_current_bit));
  opm_host_model host (.link_clk(link_clk), .frame_sel_n(frame_sel_n), .mosi(mosi), .miso(miso));

  task automatic close_out();
    if (bad_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Cuts a hung run short.
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      bad_count++;
      close_out();
    end
  end

  // The reply pin must be driven whenever the link clock runs inside a frame.
  always @(posedge link_clk) begin
    if (miso_oe_n !== 1'h0) begin
      bad_count++;
      $display("CHECK FAILED miso_oe_n expected 0 seen %b", miso_oe_n);
    end
  end

  // Each finished frame is matched against the oldest noted expectation.
  initial begin
    forever begin
      @(host.done_ev);
      e = exp_q.pop_front();
      got = {chan_drive, diag_enable, host.rsp};
      checked++;
      if ((got & e.m) !== (e.v & e.m)) begin
        bad_count++;
        $display("CHECK FAILED status expected %h seen %h", e.v & e.m, got & e.m);
      end
    end
  end

  function automatic opm_word_t wr(logic [2:0] a, logic [3:0] d);
    return {1'h1, a, 8'h00, d};
  endfunction
  function automatic opm_word_t rd(logic [2:0] a);
    return {1'h0, a, 12'h000};
  endfunction
  // Packs channels, diagnosis and the reply fields into one expected word.
  function automatic logic [20:0] ex(logic [3:0] ch, logic dg, logic [1:0] md,
    logic [2:0] tul, logic [3:0] fl, logic [3:0] da);
    return {ch, dg, md, tul, 3'h0, fl, da};
  endfunction

  task automatic fr(input opm_word_t w, input logic [20:0] v, input logic [20:0] m);
    exp_q.push_back('{v, m});
    host.xfer(w);
  endtask

  // Moves the pins and supply levels, then lets the mode settle.
  task automatic setp(input logic idl, input logic [1:0] pins, input opm_supply_t sup);
    @(posedge clk_sys);
    idle_pin <= idl;
    direct_ctrl_pin <= pins;
    supply <= sup;
    repeat (10) @(posedge clk_sys);
  endtask

  initial begin
    repeat (4) @(posedge clk_sys);
    resetn <= 1'h1;
    setp(1'h0, 2'h0, 5'h11);
    setp(1'h1, 2'h0, 5'h00);
    setp(1'h1, 2'h0, 5'h11);
    fr(wr(`OPM_ADDR_CHAN_ON, 4'h5), ex(4'h0, 1'h0, MI, 3'h0, 4'h0, 4'h0), K_SD);
    fr(rd(`OPM_ADDR_CHAN_ON), ex(4'h5, 1'h1, MA, 3'h0, 4'h0, 4'h0), K_SD);
    fr(wr(`OPM_ADDR_CHAN_ON, 4'h0), ex(4'h5, 1'h1, MA, 3'h0, 4'h0, 4'h5), K_SD | K_MD | K_DA);
    fr(wr(`OPM_ADDR_CHAN_ON, 4'h1), ex(4'h0, 1'h0, MI, 3'h0, 4'h0, 4'h0), K_SD);
    fr(wr(`OPM_ADDR_HW_CTRL, 4'h1), '0, '0);
    fr(wr(`OPM_ADDR_CHAN_ON, 4'h0), '0, '0);
    fr(rd(`OPM_ADDR_HW_CTRL), ex(4'h0, 1'h1, MA, 3'h0, 4'h0, 4'h0), K_SD | K_MD);
    fr(wr(`OPM_ADDR_HW_CTRL, 4'h0), ex(4'h0, 1'h1, MA, 3'h0, 4'h0, 4'h1), K_SD | K_DA);
    fr(wr(`OPM_ADDR_ROUTE_A, 4'h0), ex(4'h0, 1'h0, MI, 3'h0, 4'h0, 4'h0), K_SD);
    fr(wr(`OPM_ADDR_ROUTE_B, 4'h0), '0, '0);
    setp(1'h1, 2'h1, 5'h11);
    fr(rd(`OPM_ADDR_ROUTE_A), ex(4'h0, 1'h1, MA, 3'h0, 4'h0, 4'h0), K_SD);
    fr(rd(`OPM_ADDR_ROUTE_B), ex(4'h0, 1'h1, MA, 3'h0, 4'h0, 4'h0), K_SD | K_MD | K_DA);
    fr(wr(`OPM_ADDR_OL_TEST, 4'hF), '0, '0);
    fr(rd(`OPM_ADDR_OL_TEST), '0, '0);
    setp(1'h0, 2'h1, 5'h11);
    fr(rd(`OPM_ADDR_ROUTE_A), ex(4'h4, 1'h0, ML, 3'h0, 4'h0, 4'hF), K_SD | K_DA);
    fr(wr(`OPM_ADDR_CHAN_ON, 4'hF), ex(4'h4, 1'h0, ML, 3'h7, 4'h0, 4'h4), K_SD | K_MD | K_TE | K_UL | K_DA);
    fr(wr(`OPM_ADDR_OL_TEST, 4'hF), ex(4'h4, 1'h0, ML, 3'h7, 4'h0, 4'h0), K_SD | K_MD | K_TE | K_UL);
    fr(rd(`OPM_ADDR_CHAN_ON), ex(4'h4, 1'h0, ML, 3'h3, 4'h0, 4'h0), K_SD | K_MD | K_TE | K_UL);
    fr(rd(`OPM_ADDR_OL_TEST), ex(4'h4, 1'h0, ML, 3'h3, 4'h0, 4'h0), K_SD | K_DA);
    fr(rd(`OPM_ADDR_OL_TEST), ex(4'h4, 1'h0, ML, 3'h3, 4'h0, 4'h0), K_DA);
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      p = (r[1:0] == 2'h0) ? 2'h3 : r[1:0];
      @(posedge clk_sys);
      output_monitor_bit <= r[7:4];
      setp(1'h0, p, 5'h11);
      fr(rd(`OPM_ADDR_MONITOR), ex({p[1], p[0], 2'h0}, 1'h0, ML, 3'h0, 4'h0, 4'h0), K_SD);
      fr(rd(`OPM_ADDR_MONITOR), ex(4'h0, 1'h0, ML, 3'h0, 4'h0, r[7:4]), K_DA);
    end
    setp(1'h1, 2'h1, 5'h11);
    fr(rd(`OPM_ADDR_ROUTE_A), ex(4'h4, 1'h1, MA, 3'h0, 4'h0, 4'h0), K_SD);
    fr(rd(`OPM_ADDR_ROUTE_A), ex(4'h4, 1'h1, MA, 3'h0, 4'h0, 4'h4), K_SD | K_MD | K_DA);
    @(posedge clk_sys);
    fault_event <= 4'h3;
    supply <= 5'h19;
    @(posedge clk_sys);
    fault_event <= 4'h0;
    setp(1'h1, 2'h1, 5'h11);
    fr(wr(`OPM_ADDR_HW_CTRL, 4'h2), '0, '0);
    fr(rd(`OPM_ADDR_FAULT), ex(4'h4, 1'h1, MA, 3'h2, 4'h3, 4'h0), K_SD | K_UL | K_FL);
    fr(rd(`OPM_ADDR_FAULT), ex(4'h4, 1'h1, MA, 3'h0, 4'h3, 4'h3), K_UL | K_FL | K_DA);
    setp(1'h1, 2'h0, 5'h11);
    fr(wr(`OPM_ADDR_FAULT, 4'hF), ex(4'h0, 1'h0, MI, 3'h0, 4'h3, 4'h3), K_SD);
    fr(rd(`OPM_ADDR_FAULT), ex(4'h0, 1'h0, MI, 3'h0, 4'h3, 4'h0), K_SD | K_FL);
    fr(wr(`OPM_ADDR_CHAN_ON, 4'h1), ex(4'h0, 1'h0, MI, 3'h0, 4'h3, 4'h3), K_FL | K_DA);
    fr(rd(`OPM_ADDR_CHAN_ON), ex(4'h1, 1'h1, MA, 3'h0, 4'h0, 4'h0), K_SD);
    setp(1'h1, 2'h0, 5'h15);
    fr(rd(`OPM_ADDR_CHAN_ON), ex(4'h0, 1'h0, MI, 3'h0, 4'h0, 4'h0), K_SD);
    fr(rd(`OPM_ADDR_CHAN_ON), ex(4'h0, 1'h0, MI, 3'h0, 4'h0, 4'h0), K_MD | K_DA);
    setp(1'h1, 2'h0, 5'h11);
    fr(wr(`OPM_ADDR_CHAN_ON, 4'h2), '0, '0);
    setp(1'h0, 2'h0, 5'h11);
    setp(1'h1, 2'h0, 5'h11);
    fr(rd(`OPM_ADDR_CHAN_ON), '0, '0);
    fr(rd(`OPM_ADDR_CHAN_ON), ex(4'h0, 1'h0, MI, 3'h0, 4'h0, 4'h0), K_SD | K_MD | K_DA);
    repeat (10) @(posedge clk_sys);
    close_out();
  end
endmodule

bind opm_ctrl opm_ctrl_monitor #(.NUM_CH(NUM_CH), .NUM_IN(NUM_IN)) u_mon (
  .clk_sys(clk_sys), .resetn(resetn), .idle_pin(idle_pin),
  .direct_ctrl_pin(direct_ctrl_pin), .supply(supply), .chan_drive(chan_drive),
  .diag_enable(diag_enable), .serial_ready(serial_ready), .mode_code(mode_code),
  .open_load_test_current_bit(open_load_test_current_bit));
